/* src/flash_pkg.sv */
// Shared constants and carriers of the serial flash front end.
// Assumes a 250 MHz core clock; all serial pins arrive asynchronously.
package flash_pkg;

  // Clock and power-up timing
  localparam int CLK_KHZ          = 250000;
  localparam int SELECT_DELAY_US  = 70;
  localparam int WRITE_DELAY_MS   = 20;
  // Least time: round up to whole cycles
  localparam int SELECT_CYCLES_DFLT =
    (SELECT_DELAY_US * CLK_KHZ + 999) / 1000;
  // Longest time: round down
  localparam int WRITE_CYCLES_DFLT = WRITE_DELAY_MS * CLK_KHZ;
  localparam int CNT_W            = 23;

  // Instruction framing
  localparam int          OPC_W       = 8;
  localparam int          PAGE_W      = 13;
  localparam int          BYTE_W      = 10;
  localparam int          DC_W        = 1;
  localparam int          ADDR_W      = DC_W + PAGE_W + BYTE_W;
  localparam int          DUMMY_BYTES = 4;
  localparam int          BITCNT_W    = 5;
  localparam logic [7:0]  OPC_CONT_READ = 8'he8;
  localparam logic [BITCNT_W-1:0] OPC_LAST   = 5'h07;
  localparam logic [BITCNT_W-1:0] ADDR_LAST  = 5'h17;
  localparam logic [BITCNT_W-1:0] DUMMY_LAST = 5'h1f;
  localparam logic [2:0]  BIT_LAST    = 3'h7;

  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01,
    ST_OPCODE  = 6'h02,
    ST_ADDR    = 6'h04,
    ST_DUMMY   = 6'h08,
    ST_DATA    = 6'h10,
    ST_IGNORE  = 6'h20
  } serial_state_e;

  typedef struct packed {
    logic [OPC_W-1:0]  opcode;
    logic [PAGE_W-1:0] page;
    logic [BYTE_W-1:0] byte_addr;
  } flash_cmd_s;

endpackage

/* src/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Pins and result
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  // Reset value applied after the flops so no port reaches async reset
  logic [W-1:0] rst_seen_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_seen_q <= '0;
    end else begin
      rst_seen_q <= '1;
    end
  end

  assign sync_o = (sync_q & rst_seen_q) | (rst_val & ~rst_seen_q);

endmodule

/* src/flash_serial_power_on_state.sv */
// Serial front end of a flash device: power-up timing, mode pick,
// instruction framing and serial output enable.
// Assumes sck, cs_n and si arrive from pins; user logic on clock.
//
// Contract
// - After power-up or reset the device defaults to clock mode 3.
// - After reset the serial output is undriven until read data flows.
// - Instructions start only on a high-to-low chip select transition.
// - Each chip select fall samples idle clock: high mode 3, low mode 0.
// - While held in reset all operations stop and commands are ignored.
// - After power-up the device rests in standby until selected.
// - E8h carries 1 don't-care, 13 page, 10 byte bits, 4 dummy bytes.
`timescale 1ns/100ps
module flash_serial_power_on_state #(
  parameter int unsigned SELECT_CYCLES = flash_pkg::SELECT_CYCLES_DFLT,
  parameter int unsigned WRITE_CYCLES  = flash_pkg::WRITE_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Serial pins
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 si,
  output logic                      so_o,
  output logic                      so_oe,
  // Status
  output logic                      mode3,
  output logic                      standby,
  output logic                      select_ok,
  output logic                      write_enable_delay_done,
  output logic                      early_select,
  // Decoded instruction
  output flash_pkg::flash_cmd_s     cmd,
  output logic                      cmd_valid,
  // Read data supply
  output logic                      rd_req,
  input  wire logic [7:0]           rd_data
);
  import flash_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges

  logic [2:0] pins_s;
  logic       sck_s;
  logic       cs_s;
  logic       si_s;
  logic       sck_prev_q;
  logic       cs_prev_q;

  // Idle pin levels: clock high, deselected
  pin_sync #(.W(3)) u_sync (
    .clock   (clock),
    .nrst    (nrst),
    .async_i ({sck, cs_n, si}),
    .rst_val (3'h6),
    .sync_o  (pins_s)
  );

  assign sck_s = pins_s[2];
  assign cs_s  = pins_s[1];
  assign si_s  = pins_s[0];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sck_prev_q <= 1'b1;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
    end
  end

  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire cs_fall  = ~cs_s & cs_prev_q;
  wire cs_high  = cs_s;

  ////////////////////////////////////////////////////////////////////////
  // Power-up delay counters

  logic [CNT_W-1:0] sel_cnt_q;
  logic [CNT_W-1:0] wr_cnt_q;
  logic             sel_ok_q;
  logic             wr_ok_q;

  wire sel_done = sel_cnt_q >= CNT_W'(SELECT_CYCLES);
  wire wr_done  = wr_cnt_q >= CNT_W'(WRITE_CYCLES);

  // Counters run from reset release; the device only reports readiness
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_cnt_q <= '0;
      wr_cnt_q  <= '0;
      sel_ok_q  <= 1'b0;
      wr_ok_q   <= 1'b0;
    end else begin
      sel_cnt_q <= sel_done ? sel_cnt_q : sel_cnt_q + 1'b1;
      wr_cnt_q  <= wr_done ? wr_cnt_q : wr_cnt_q + 1'b1;
      sel_ok_q  <= sel_done;
      wr_ok_q   <= wr_done;
    end
  end

  assign select_ok               = sel_ok_q;
  assign write_enable_delay_done = wr_ok_q;

  ////////////////////////////////////////////////////////////////////////
  // Select arming and mode pick

  logic       armed_q;
  logic       mode3_q;
  logic       early_q;
  // Synchroniser shows its reset level for two edges; arm on real pins only
  logic [1:0] live_q;

  // Chip select already low at reset release never starts a frame
  wire frame_start = cs_fall & armed_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      armed_q <= 1'b0;
      mode3_q <= 1'b1;
      early_q <= 1'b0;
      live_q  <= '0;
    end else begin
      live_q  <= {live_q[0], 1'b1};
      armed_q <= armed_q | (cs_high & live_q[1]);
      if (frame_start) begin
        mode3_q <= sck_s;
      end
      // Sticky flag for a select before the select delay ran out
      if (frame_start && !sel_ok_q) begin
        early_q <= 1'b1;
      end
    end
  end

  assign mode3        = mode3_q;
  assign early_select = early_q;

  ////////////////////////////////////////////////////////////////////////
  // Instruction framing

  serial_state_e    state_q;
  serial_state_e    state_d;
  logic [BITCNT_W-1:0] bit_q;
  logic [ADDR_W-1:0]   shin_q;
  logic [OPC_W-1:0]    opc_q;
  logic [2:0]          dummy_q;
  logic                seen_rise_q;

  wire in_frame  = ~state_q[0];
  wire [ADDR_W-1:0] shin_next = {shin_q[ADDR_W-2:0], si_s};
  // Mode 3 opens with a falling edge that carries no bit
  wire edge_ok   = ~mode3_q | seen_rise_q;
  wire take_bit  = sck_rise & in_frame;
  wire opc_end   = take_bit & (state_q == ST_OPCODE) & (bit_q == OPC_LAST);
  wire is_read   = shin_next[OPC_W-1:0] == OPC_CONT_READ;
  wire addr_end  = take_bit & (state_q == ST_ADDR) & (bit_q == ADDR_LAST);
  wire dummy_end = take_bit & (state_q == ST_DUMMY) &
                   (bit_q[2:0] == BIT_LAST) &
                   (dummy_q == 3'(DUMMY_BYTES - 1));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STANDBY: if (frame_start) state_d = ST_OPCODE;
      ST_OPCODE:  if (opc_end) state_d = is_read ? ST_ADDR : ST_IGNORE;
      ST_ADDR:    if (addr_end) state_d = ST_DUMMY;
      ST_DUMMY:   if (dummy_end) state_d = ST_DATA;
      ST_DATA:    state_d = ST_DATA;
      ST_IGNORE:  state_d = ST_IGNORE;
    endcase
    // Deselect always ends the frame and returns to standby
    if (cs_high) state_d = ST_STANDBY;
  end

  // Reset holds everything idle, so no command can be taken
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q     <= ST_STANDBY;
      bit_q       <= '0;
      shin_q      <= '0;
      opc_q       <= '0;
      dummy_q     <= '0;
      seen_rise_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (!in_frame) begin
        bit_q       <= '0;
        dummy_q     <= '0;
        seen_rise_q <= 1'b0;
      end else if (take_bit) begin
        seen_rise_q <= 1'b1;
        shin_q      <= shin_next;
        bit_q       <= (opc_end || addr_end) ? '0 : bit_q + 1'b1;
        if (opc_end) begin
          opc_q <= shin_next[OPC_W-1:0];
        end
        if (state_q == ST_DUMMY && bit_q[2:0] == BIT_LAST) begin
          dummy_q <= dummy_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded instruction report

  flash_cmd_s cmd_q;
  logic       cmd_valid_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_q       <= '0;
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      if (opc_end && !is_read) begin
        cmd_q       <= '{opcode: shin_next[OPC_W-1:0], page: '0,
                         byte_addr: '0};
        cmd_valid_q <= 1'b1;
      end else if (addr_end) begin
        // Top address bit is a don't-care and is dropped
        cmd_q       <= '{opcode: opc_q,
                         page: shin_next[BYTE_W +: PAGE_W],
                         byte_addr: shin_next[BYTE_W-1:0]};
        cmd_valid_q <= 1'b1;
      end
    end
  end

  assign cmd       = cmd_q;
  assign cmd_valid = cmd_valid_q;
  assign standby   = state_q == ST_STANDBY;

  ////////////////////////////////////////////////////////////////////////
  // Serial output

  logic [7:0] shout_q;
  logic [2:0] out_cnt_q;
  logic       so_q;
  logic       oe_q;

  wire out_edge = sck_fall & (state_q == ST_DATA) & edge_ok & ~cs_high;
  wire reload   = dummy_end | (out_edge & (out_cnt_q == BIT_LAST));

  assign rd_req = reload & ~cs_high;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shout_q   <= '0;
      out_cnt_q <= '0;
      so_q      <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      if (dummy_end) begin
        shout_q   <= rd_data;
        out_cnt_q <= '0;
      end else if (out_edge) begin
        so_q      <= shout_q[7];
        oe_q      <= 1'b1;
        out_cnt_q <= out_cnt_q + 1'b1;
        shout_q   <= reload ? rd_data : {shout_q[6:0], 1'b0};
      end
      // Released on deselect whatever mode the frame used
      if (cs_high) begin
        oe_q <= 1'b0;
      end
    end
  end

  assign so_o  = so_q;
  assign so_oe = oe_q;

endmodule

/* tb/flash_serial_power_on_state_asserts.sv */
// Port checker for the flash serial front end.
// Assumes bind to the top module; counts are the top's parameters.
`timescale 1ns/100ps
module flash_serial_power_on_state_asserts
  import flash_pkg::*;
#(
  parameter int unsigned SELECT_CYCLES = 20,
  parameter int unsigned WRITE_CYCLES  = 40
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Serial pins
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       si,
  input wire logic       so_o,
  input wire logic       so_oe,
  // Status
  input wire logic       mode3,
  input wire logic       standby,
  input wire logic       select_ok,
  input wire logic       write_enable_delay_done,
  input wire logic       early_select,
  // Decoded instruction and read data
  input wire flash_cmd_s cmd,
  input wire logic       cmd_valid,
  input wire logic       rd_req,
  input wire logic [7:0] rd_data
);
  logic [15:0] cnt_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Edges since release, saturating
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) cnt_q <= '0;
    else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  rst_state_a:
    assert property ($rose(nrst) |-> mode3 && standby && !so_oe)
      else $error("bad state after reset");
  rst_quiet_a:
    assert property ($rose(nrst) |-> (!cmd_valid && !rd_req) [*4])
      else $error("activity right after reset");
  oe_idle_a:
    assert property (cs_n [*5] |-> !so_oe) else $error("so driven idle");
  standby_idle_a:
    assert property (cs_n [*5] |-> standby) else $error("not standby");
  mode_pick_a:
    assert property ($fell(cs_n) && standby ##1
      (!cs_n && $stable(sck)) [*4] |-> mode3 == sck)
      else $error("mode not taken from idle clock");
  rd_e8_a:
    assert property (rd_req |-> cmd.opcode == OPC_CONT_READ)
      else $error("read outside continuous read");
  sel_early_a:
    assert property (cnt_q < SELECT_CYCLES |-> !select_ok)
      else $error("select ok too soon");
  sel_late_a:
    assert property (cnt_q > SELECT_CYCLES + 3 |-> select_ok)
      else $error("select ok too late");
  wr_early_a:
    assert property (cnt_q < WRITE_CYCLES |-> !write_enable_delay_done)
      else $error("write delay done too soon");
  wr_late_a:
    assert property (cnt_q > WRITE_CYCLES + 3 |-> write_enable_delay_done)
      else $error("write delay done too late");
endmodule

bind flash_serial_power_on_state flash_serial_power_on_state_asserts #(
  .SELECT_CYCLES(SELECT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) chk_i (
  .clock, .nrst, .sck, .cs_n, .si, .so_o, .so_oe, .mode3, .standby,
  .select_ok, .write_enable_delay_done, .early_select, .cmd, .cmd_valid,
  .rd_req, .rd_data);

/* tb/host_model.sv */
// Host serial master model: frames, clock modes and read-back.
// Assumes the core clock; each clock phase lasts five core cycles.
`timescale 1ns/100ps
module host_model (
  // Core clock
  input  wire logic clock,
  // Device serial pins
  input  wire logic so_o,
  input  wire logic so_oe,
  output logic      sck,
  output logic      cs_n,
  output logic      si
);
  initial begin
    sck = 1'b1;
    cs_n = 1'b1;
    si = 1'b0;
  end

  task automatic xfer(input logic m3, input logic [63:0] bits,
                      input int n, input int nrd, output logic [15:0] got);
    got = '0;
    @(posedge clock) sck <= m3;
    repeat (6) @(posedge clock);
    cs_n <= 1'b0;
    repeat (6) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      si <= bits[63-i];
      repeat (5) @(posedge clock);
      sck <= 1'b1;
      repeat (5) @(posedge clock);
    end
    for (int i = 0; i < nrd; i++) begin
      sck <= 1'b0;
      si <= ~si;
      repeat (5) @(posedge clock);
      got = {got[14:0], so_oe ? so_o : 1'bx};
      sck <= 1'b1;
      repeat (5) @(posedge clock);
    end
    sck <= m3;
    repeat (5) @(posedge clock);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge clock);
  endtask
endmodule

/* tb/flash_serial_power_on_state_bench.sv */
// Self-checking bench for the flash serial front end.
// Assumes the host model drives the pins; short power-up counts.
`timescale 1ns/100ps
module flash_serial_power_on_state_bench;
  import flash_pkg::*;
  logic        clock = 1'b0, nrst = 1'b0;
  logic [7:0]  rd_data = 8'h00;
  logic        sck, cs_n, si, so_o, so_oe, mode3, standby, select_ok;
  logic        wdone, early_select, cmd_valid, rd_req;
  flash_cmd_s  cmd;
  flash_cmd_s  exp_q[$];
  int          num_errors = 0, n_compared = 0;
  int          n_rdreq = 0;
  logic [31:0] seed = 32'h000022c0;
  logic [15:0] got;

  always #2 clock = ~clock;

  flash_serial_power_on_state #(.SELECT_CYCLES(20), .WRITE_CYCLES(40))
    flash_serial_power_on_state_i (.clock, .nrst, .sck, .cs_n, .si,
    .so_o, .so_oe, .mode3, .standby, .select_ok,
    .write_enable_delay_done(wdone), .early_select, .cmd, .cmd_valid,
    .rd_req, .rd_data);
  host_model host_model_i (.clock, .so_o, .so_oe, .sck, .cs_n, .si);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    next_rand = r ^ (r << 5);
  endfunction

  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Any decode with nothing queued is a fault
  always @(negedge clock) begin
    if (rd_req === 1'b1) n_rdreq++;
    if (cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(0, 1, "unexpected cmd");
      else chk(cmd, exp_q.pop_front(), "cmd");
    end
  end

  task automatic frame(input logic m3, input logic [7:0] op, input int nrd);
    logic [23:0] a;
    int          r0;
    seed = next_rand(seed);
    a = seed[23:0];
    r0 = n_rdreq;
    @(posedge clock) rd_data <= seed[31:24];
    exp_q.push_back(op == OPC_CONT_READ ? {op, a[22:10], a[9:0]}
                                        : {op, 23'h0});
    host_model_i.xfer(m3, {op, a, 32'h0}, op == OPC_CONT_READ ? 64 : 16,
                      nrd, got);
    chk(mode3, m3, "mode");
    if (nrd > 0) chk(got[7:0], rd_data, "read byte");
    // One fetch after the dummy bytes, then one per byte shifted out
    r0 = n_rdreq - r0;
    chk(r0, (nrd > 0) ? 1 + nrd / 8 : 0, "rd_req count");
    repeat (4) @(negedge clock);
    chk(so_oe, 0, "oe after frame");
    chk(standby, 1, "standby");
    $display("frame %h mode %0d done", op, m3);
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 100 && select_ok !== 1'b1; i++) @(negedge clock);
    chk(select_ok, 1, "select ok");
  endtask

  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk(mode3, 1, "reset mode");
    chk(so_oe, 0, "reset oe");
    chk(standby, 1, "reset standby");
    wait_ready();
    chk(wdone, 0, "write delay early");
    chk(early_select, 0, "early select");
    frame(1'b0, OPC_CONT_READ, 8);
    frame(1'b1, OPC_CONT_READ, 8);
    chk(wdone, 1, "write delay done");
    frame(1'b1, 8'hd2, 0);
    fork
      host_model_i.xfer(1'b0, {64{1'b1}}, 64, 0, got);
      begin
        repeat (60) @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
      end
    join
    chk(mode3, 1, "mode after reset");
    $display("reset in frame done");
    wait_ready();
    frame(1'b0, OPC_CONT_READ, 8);
    // Select straight after reset is served but flagged
    @(posedge clock) nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    frame(1'b1, 8'hd2, 0);
    chk(early_select, 1, "early select set");
    complete_run();
  end

  initial begin
    #60000;
    num_errors++;
    complete_run();
  end
endmodule
